// ==== src/cal_seq_pkg.sv ====
// Package: register map, field layout, modes and timing of the calibration sequencer
package cal_seq_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] SETUP_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] DATA_OFS     = 8'h08;
  localparam logic [7:0] ZS_CAL_OFS   = 8'h0C;
  localparam logic [7:0] FS_CAL_OFS   = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] IRQ_CLR_OFS  = 8'h18;
  localparam logic [7:0] IRQ_EN_OFS   = 8'h1C;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int         MODE_LSB      = 0;
  localparam int         GAIN_LSB      = 2;
  localparam int         FILT_LSB      = 4;
  localparam int         BIP_BIT       = 6;
  localparam logic [6:0] SETUP_RST     = 7'h00;
  localparam int         STAT_BUSY_BIT = 2;
  localparam int         STAT_RDY_BIT  = 3;
  localparam int         IRQ_CAL_BIT   = 0;
  localparam int         IRQ_WORD_BIT  = 1;
  localparam logic [1:0] IRQ_RST       = 2'h0;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // Nominal coefficients loaded at reset, and the slope loaded when the span is not positive
  localparam logic [23:0] ZS_CAL_RST = 24'h000000;
  localparam logic [23:0] FS_CAL_RST = 24'h400000;
  localparam logic [32:0] COEF_RST   = 33'h000000400;
  localparam logic [32:0] COEF_MAX   = 33'h1FFFFFFFF;

  // ****************************************
  // Modes and states
  // ****************************************
  typedef enum logic [1:0] {
    MODE_NORMAL   = 2'h0,
    MODE_SELF     = 2'h1,
    MODE_SYS_ZERO = 2'h2,
    MODE_SYS_FULL = 2'h3
  } cal_mode_t;

  typedef enum logic [1:0] {
    IN_ANALOG = 2'h0,
    IN_BIAS   = 2'h1,
    IN_REF    = 2'h2
  } in_sel_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ZERO = 4'b0010,
    ST_FULL = 4'b0100,
    ST_CONV = 4'b1000
  } state_t;

  // ****************************************
  // Timing
  // ****************************************
  localparam int         MOD_CLKS        = 128;
  localparam logic [6:0] MOD_LAST        = 7'(MOD_CLKS - 1);
  localparam logic [7:0] DECIM_0         = 8'h10;
  localparam logic [7:0] DECIM_1         = 8'h20;
  localparam logic [7:0] DECIM_2         = 8'h40;
  localparam logic [7:0] DECIM_3         = 8'h80;
  localparam int         CAL_PERIODS     = 3;
  localparam int         SELF_CONV_PER   = 3;
  localparam int         SYS_CONV_PER    = 1;
  localparam logic [1:0] CAL_LAST        = 2'(CAL_PERIODS - 1);
  localparam logic [1:0] SELF_CONV_LAST  = 2'(SELF_CONV_PER - 1);
  localparam logic [1:0] SYS_CONV_LAST   = 2'(SYS_CONV_PER - 1);
  localparam logic [5:0] DIV_STEPS       = 6'h21;

endpackage : cal_seq_pkg

// ==== src/rate_if.sv ====
// Interface between the sequencer and its output-rate divider
`timescale 1ns/1ps
interface rate_if;
  logic       restart;
  logic [1:0] filter_sel;
  logic       mod_tick;
  logic       out_tick;

  modport ctrl (output restart, output filter_sel, input mod_tick, input out_tick);
  modport gen  (input restart, input filter_sel, output mod_tick, output out_tick);
endinterface : rate_if

// ==== src/rate_divider.sv ====
// Modulator-cycle and output-period enable generator
`timescale 1ns/1ps
module rate_divider
  import cal_seq_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // Rate control
  rate_if.gen       rate
);

  logic [6:0] clk_cnt_r;
  logic [7:0] mod_cnt_r;

  wire       last_clk = clk_cnt_r == MOD_LAST;
  wire [7:0] decim    = rate.filter_sel == 2'h0 ? DECIM_0 :
                        rate.filter_sel == 2'h1 ? DECIM_1 :
                        rate.filter_sel == 2'h2 ? DECIM_2 : DECIM_3;
  wire       last_mod = mod_cnt_r >= decim - 8'h01;

  // Restart realigns output periods to the calibration command
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || rate.restart)
    begin
      clk_cnt_r     <= 7'h00;
      mod_cnt_r     <= 8'h00;
      rate.mod_tick <= 1'b0;
      rate.out_tick <= 1'b0;
    end
    else
    begin
      clk_cnt_r     <= last_clk ? 7'h00 : clk_cnt_r + 7'h01;
      rate.mod_tick <= last_clk;
      rate.out_tick <= last_clk && last_mod;
      if (last_clk)
        mod_cnt_r <= last_mod ? 8'h00 : mod_cnt_r + 8'h01;
    end
  end

endmodule : rate_divider

// ==== src/cal_sequencer.sv ====
// Calibration sequencer of a sigma-delta converter with AXI4-Lite register access
//
// Contract
// - Calibration starts at any moment, only by writing the setup mode field.
// - Mode 01 runs self calibration of zero-scale and full-scale points.
// - Self calibration uses shorted bias inputs, then reference over gain.
// - Self calibration takes six periods; mode field then returns to 00.
// - Any calibration start raises ready-n until a fresh word exists.
// - After self calibration command, ready-n falls nine periods later.
// - Ready-n may take up to one modulator cycle to rise.
// - Bipolar self calibration maps the shorted point to midscale.
// - Mode 10 runs three-period system zero-scale step, then field 00.
// - Mode 11 runs three-period system full-scale step, then field 00.
// - Each system step lowers ready-n four periods after its command.
// - System calibration uses endpoints unipolar, midscale and full scale bipolar.
// - Repeating one system step leaves the other coefficient unchanged.
// - Zero and full-scale results stored separately; offset and slope derived.
// - Conversion uses 33-bit internal resolution for the 16-bit result.
`timescale 1ns/1ps
module cal_sequencer
  import cal_seq_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Converter side
  input  wire logic [23:0] filt_word_i,
  output logic             conv_ready_n_o,
  output logic [1:0]       in_sel_o,
  output logic [1:0]       gain_sel_o,
  output logic             bipolar_o,
  output logic             irq_o
);

  // ****************************************
  // Conversion arithmetic
  // ****************************************
  // Offset removal and slope scaling; coef is 2^32 over the calibrated span
  function automatic logic [15:0] to_code(input logic [23:0] raw,
                                          input logic [23:0] zs,
                                          input logic [32:0] coef,
                                          input logic        bip);
    logic signed [24:0] diff;
    logic signed [58:0] prod;
    logic signed [58:0] val;
    diff = $signed({raw[23], raw}) - $signed({zs[23], zs});
    prod = diff * $signed({1'b0, coef});
    val  = bip ? (prod >>> 17) + 59'sh0008000 : (prod >>> 16);
    if (val < 0)
      to_code = 16'h0000;
    else if (val > 59'sh000FFFF)
      to_code = 16'hFFFF;
    else
      to_code = val[15:0];
  endfunction : to_code

  // ****************************************
  // Declarations
  // ****************************************
  logic        awready_r;
  logic        wready_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [6:0]  setup_r;
  state_t      state_r;
  logic        self_r;
  logic [1:0]  per_cnt_r;
  logic [1:0]  in_sel_r;
  logic        ready_n_r;
  logic [15:0] data_r;
  logic [23:0] zs_cal_r;
  logic [23:0] fs_cal_r;
  logic [32:0] coef_r;
  logic        div_go_r;
  logic [5:0]  div_cnt_r;
  logic [24:0] div_rem_r;
  logic [24:0] div_den_r;
  logic [32:0] div_q_r;
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_en_r;
  logic        irq_r;
  logic        pend_r;
  logic [3:0]  cal_ticks_r;

  rate_if rate ();

  rate_divider u_rate (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .rate      (rate.gen)
  );

  // ****************************************
  // AXI4-Lite decode
  // ****************************************
  wire aw_hs   = s_axi_awvalid_i && awready_r;
  wire w_hs    = s_axi_wvalid_i && wready_r;
  wire wr_go   = aw_hold_r && w_hold_r && !bvalid_r;
  wire ar_hs   = s_axi_arvalid_i && arready_r;
  wire wr_ok   = awaddr_r == SETUP_OFS || awaddr_r == IRQ_CLR_OFS || awaddr_r == IRQ_EN_OFS;
  wire wr_lo   = wr_go && wstrb_r[0];
  wire setup_wr = wr_lo && awaddr_r == SETUP_OFS;
  wire clr_wr  = wr_lo && awaddr_r == IRQ_CLR_OFS;
  wire en_wr   = wr_lo && awaddr_r == IRQ_EN_OFS;
  wire data_rd = ar_hs && s_axi_araddr_i == DATA_OFS;

  wire [31:0] status_word = {28'h0000000, ready_n_r, state_r != ST_IDLE,
                             setup_r[MODE_LSB +: 2]};
  wire        rd_ok   = s_axi_araddr_i[7:5] == 3'h0 && s_axi_araddr_i[1:0] == 2'h0;
  wire [31:0] rd_word =
      s_axi_araddr_i == SETUP_OFS    ? {25'h0000000, setup_r} :
      s_axi_araddr_i == STATUS_OFS   ? status_word :
      s_axi_araddr_i == DATA_OFS     ? {16'h0000, data_r} :
      s_axi_araddr_i == ZS_CAL_OFS   ? {8'h00, zs_cal_r} :
      s_axi_araddr_i == FS_CAL_OFS   ? {8'h00, fs_cal_r} :
      s_axi_araddr_i == IRQ_STAT_OFS ? {30'h00000000, irq_stat_r} :
      s_axi_araddr_i == IRQ_EN_OFS   ? {30'h00000000, irq_en_r} : 32'h00000000;

  // ****************************************
  // Write channels
  // ****************************************
  // Address and data are taken in either order; one write in flight
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
      begin
        awaddr_r  <= s_axi_awaddr_i;
        aw_hold_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (w_hs)
      begin
        wdata_r  <= s_axi_wdata_i;
        wstrb_r  <= s_axi_wstrb_i;
        w_hold_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_go)
      begin
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
      end
      if (bvalid_r && s_axi_bready_i)
      begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // ****************************************
  // Read channels
  // ****************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_word;
      rresp_r   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready_i)
    begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ****************************************
  // Calibration sequencer
  // ****************************************
  wire [1:0] new_mode  = wdata_r[MODE_LSB +: 2];
  wire       cal_start = setup_wr && new_mode != MODE_NORMAL;
  wire       tick      = rate.out_tick && !setup_wr;
  wire       step_end  = tick && per_cnt_r == CAL_LAST;
  wire       zero_end  = state_r == ST_ZERO && step_end;
  wire       full_end  = state_r == ST_FULL && step_end;
  wire [1:0] conv_last = self_r ? SELF_CONV_LAST : SYS_CONV_LAST;
  wire       conv_end  = state_r == ST_CONV && tick && per_cnt_r == conv_last;
  wire       new_word  = conv_end || (state_r == ST_IDLE && tick);
  wire       cal_done  = (zero_end && !self_r) || full_end;
  wire [15:0] code     = to_code(filt_word_i, zs_cal_r, coef_r, setup_r[BIP_BIT]);

  assign rate.restart    = setup_wr;
  assign rate.filter_sel = setup_r[FILT_LSB +: 2];

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      setup_r   <= SETUP_RST;
      state_r   <= ST_IDLE;
      self_r    <= 1'b0;
      per_cnt_r <= 2'h0;
      in_sel_r  <= IN_ANALOG;
      ready_n_r <= 1'b1;
      data_r    <= 16'h0000;
      zs_cal_r  <= ZS_CAL_RST;
      fs_cal_r  <= FS_CAL_RST;
      div_go_r  <= 1'b0;
    end
    else if (setup_wr)
    begin
      // A new command always wins, even over a calibration in progress
      setup_r   <= wdata_r[6:0];
      self_r    <= new_mode == MODE_SELF;
      per_cnt_r <= 2'h0;
      div_go_r  <= 1'b0;
      if (cal_start)
        ready_n_r <= 1'b1;
      unique case (new_mode)
        MODE_SELF:     begin state_r <= ST_ZERO; in_sel_r <= IN_BIAS;   end
        MODE_SYS_ZERO: begin state_r <= ST_ZERO; in_sel_r <= IN_ANALOG; end
        MODE_SYS_FULL: begin state_r <= ST_FULL; in_sel_r <= IN_ANALOG; end
        MODE_NORMAL:   begin state_r <= ST_IDLE; in_sel_r <= IN_ANALOG; end
      endcase
    end
    else
    begin
      div_go_r <= zero_end && !self_r || full_end;
      if (data_rd)
        ready_n_r <= 1'b1;
      if (tick)
        per_cnt_r <= (step_end || conv_end) ? 2'h0 : per_cnt_r + 2'h1;
      if (cal_done)
        setup_r[MODE_LSB +: 2] <= MODE_NORMAL;
      unique case (state_r)
        ST_ZERO:
          if (step_end)
          begin
            zs_cal_r <= filt_word_i;
            state_r  <= self_r ? ST_FULL : ST_CONV;
            in_sel_r <= self_r ? IN_REF : IN_ANALOG;
          end
        ST_FULL:
          if (step_end)
          begin
            fs_cal_r <= filt_word_i;
            state_r  <= ST_CONV;
            in_sel_r <= IN_ANALOG;
          end
        ST_CONV:
          if (conv_end)
            state_r <= ST_IDLE;
        ST_IDLE: ;
      endcase
      if (new_word)
      begin
        data_r    <= code;
        ready_n_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Slope coefficient divider
  // ****************************************
  // Serial 33-step division keeps area small; it ends long before the conversion
  wire [24:0] span   = {1'b0, fs_cal_r} - {1'b0, zs_cal_r};
  wire        span_ok = !span[24] && span != 25'h0000000;
  wire [25:0] rem_sh = {div_rem_r, div_cnt_r == DIV_STEPS};
  wire        rem_ge = rem_sh >= {1'b0, div_den_r};
  wire [25:0] rem_nx = rem_ge ? rem_sh - {1'b0, div_den_r} : rem_sh;
  wire [32:0] q_nx   = {div_q_r[31:0], rem_ge};

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      coef_r    <= COEF_RST;
      div_cnt_r <= 6'h00;
      div_rem_r <= 25'h0000000;
      div_den_r <= 25'h0000000;
      div_q_r   <= 33'h000000000;
    end
    else if (div_go_r)
    begin
      div_den_r <= span;
      div_rem_r <= 25'h0000000;
      div_q_r   <= 33'h000000000;
      div_cnt_r <= span_ok ? DIV_STEPS : 6'h00;
      if (!span_ok)
        coef_r <= COEF_MAX;
    end
    else if (div_cnt_r != 6'h00)
    begin
      div_rem_r <= rem_nx[24:0];
      div_q_r   <= q_nx;
      div_cnt_r <= div_cnt_r - 6'h01;
      if (div_cnt_r == 6'h01)
        coef_r <= q_nx;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  wire [1:0] irq_set = {new_word, cal_done};

  // A set in the same cycle as its clear is kept
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_stat_r <= IRQ_RST;
      irq_en_r   <= IRQ_RST;
      irq_r      <= 1'b0;
    end
    else
    begin
      irq_stat_r <= (irq_stat_r & ~(clr_wr ? wdata_r[1:0] : 2'h0)) | irq_set;
      if (en_wr)
        irq_en_r <= wdata_r[1:0];
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end

  // ****************************************
  // Helper for timing checks
  // ****************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      pend_r      <= 1'b0;
      cal_ticks_r <= 4'h0;
    end
    else if (cal_start)
    begin
      pend_r      <= 1'b1;
      cal_ticks_r <= 4'h0;
    end
    else
    begin
      if (new_word || setup_wr)
        pend_r <= 1'b0;
      if (rate.out_tick && cal_ticks_r != 4'hF)
        cal_ticks_r <= cal_ticks_r + 4'h1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o  = wready_r;
  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_bresp_o   = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign s_axi_rdata_o   = rdata_r;
  assign s_axi_rresp_o   = rresp_r;
  assign conv_ready_n_o  = ready_n_r;
  assign in_sel_o        = in_sel_r;
  assign gain_sel_o      = setup_r[GAIN_LSB +: 2];
  assign bipolar_o       = setup_r[BIP_BIT];
  assign irq_o           = irq_r;

  // ****************************************
  // Assertions
  // ****************************************
  a_start_ready:
  assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    cal_start |=> conv_ready_n_o)
    else $error("ready not raised after calibration start");

  a_busy_ready:
  assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_r != ST_IDLE |-> conv_ready_n_o)
    else $error("ready low while calibrating");

  a_self_nine:
  assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(conv_ready_n_o) && $past(pend_r) && $past(self_r) |-> cal_ticks_r == 4'h9)
    else $error("self calibration ready not after nine periods");

  a_sys_four:
  assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(conv_ready_n_o) && $past(pend_r) && !$past(self_r) |-> cal_ticks_r == 4'h4)
    else $error("system step ready not after four periods");

  a_mode_cleared:
  assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $rose(state_r == ST_CONV) |-> setup_r[MODE_LSB +: 2] == MODE_NORMAL
      ##0 (self_r ? cal_ticks_r == 4'h6 : cal_ticks_r == 4'h3))
    else $error("mode field not cleared at end of calibration");

  a_self_inputs:
  assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    self_r && state_r == ST_ZERO |-> in_sel_o == IN_BIAS)
    else $error("self zero-scale step not on shorted inputs");

  a_keep_other:
  assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state_r == ST_ZERO && !self_r && !setup_wr |=> $stable(fs_cal_r))
    else $error("zero-scale step disturbed full-scale coefficient");

  a_zero_store:
  assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    zero_end && !setup_wr |=> zs_cal_r == $past(filt_word_i))
    else $error("zero-scale result not stored");

  a_bip_mid:
  assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    new_word && !setup_wr && setup_r[BIP_BIT] && filt_word_i == zs_cal_r
      |=> data_r == 16'h8000 && !conv_ready_n_o)
    else $error("bipolar zero point not at midscale");

  a_tick_align:
  assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rate.out_tick |-> rate.mod_tick)
    else $error("output period not aligned to a modulator cycle");

  a_irq_level:
  assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (irq_stat_r & irq_en_r) != 2'h0 |=> irq_o)
    else $error("interrupt not raised for enabled status");

endmodule : cal_sequencer

// ==== test/filt_model.sv ====
// Behavioural filter-word source that follows the sequencer's input select
`timescale 1ns/1ps
module filt_model
  import cal_seq_pkg::*;
#(
  parameter logic [23:0] BIAS_WORD = 24'h000100,
  parameter logic [23:0] REF_WORD  = 24'h010100
)
(
  // Clock
  input  wire logic        ref_clk_i,
  // Sequencer side
  input  wire logic [1:0]  in_sel_i,
  input  wire logic [23:0] analog_i,
  output logic [23:0]      filt_word_o
);
  // One cycle late, as a real filter would never answer in the same cycle
  always_ff @(posedge ref_clk_i)
  begin
    case (in_sel_i)
      IN_BIAS: filt_word_o <= BIAS_WORD;
      IN_REF:  filt_word_o <= REF_WORD;
      default: filt_word_o <= analog_i;
    endcase
  end
endmodule : filt_model

// ==== test/testbench.sv ====
// Self-checking bench for the calibration sequencer
`timescale 1ns/1ps
module testbench;
  import cal_seq_pkg::*;
  localparam int P = int'(DECIM_0) * MOD_CLKS;
  logic        ref_clk_i, rst_n_i, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, conv_ready_n, irq, bipolar;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, in_sel, gain_sel;
  logic [23:0] filt_word, analog;
  int          err_count = 0, check_count = 0, cyc = 0, t0 = 0;

  cal_sequencer cal_sequencer_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .filt_word_i(filt_word),
    .conv_ready_n_o(conv_ready_n), .in_sel_o(in_sel), .gain_sel_o(gain_sel), .bipolar_o(bipolar),
    .irq_o(irq));
  filt_model filt_model_i (.ref_clk_i(ref_clk_i), .in_sel_i(in_sel), .analog_i(analog),
    .filt_word_o(filt_word));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // Cut a hang short well past the longest expected run
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge ref_clk_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge ref_clk_i);
      if (awready && awvalid)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && wvalid)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge ref_clk_i);
    bready <= 1'b0;
    t0 = cyc;
    chk(32'(bresp), 32'(er));
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge ref_clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge ref_clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge ref_clk_i);
    rready <= 1'b0;
    rd = rdata;
    chk(32'(rresp), 32'(er));
    if (exp !== 32'hFFFFFFFF) chk(rd, exp);
  endtask : axi_rd

  task automatic wait_to(input int t);
    while (cyc < t) @(posedge ref_clk_i);
  endtask : wait_to

  // Ready-n is judged only after one modulator cycle, as the host must
  task automatic cmd(input logic [6:0] s);
    axi_wr(SETUP_OFS, 32'(s), RESP_OKAY);
    repeat (MOD_CLKS) @(posedge ref_clk_i);
    chk(32'(conv_ready_n), 32'h1);
  endtask : cmd

  // Mode field still set just before n clocks, cleared just after
  task automatic mode_at(input int n, input logic [1:0] m);
    wait_to(t0 + n - 8);
    axi_rd(STATUS_OFS, 32'hFFFFFFFF, RESP_OKAY);
    chk(32'(rd[1:0]), 32'(m));
    wait_to(t0 + n + 8);
    axi_rd(STATUS_OFS, 32'hFFFFFFFF, RESP_OKAY);
    chk(32'(rd[1:0]), 32'(MODE_NORMAL));
  endtask : mode_at

  task automatic ready_low(input int n);
    while (conv_ready_n !== 1'b0) @(posedge ref_clk_i);
    chk(32'((cyc - t0 >= n - 3) && (cyc - t0 <= n + 3)), 32'h1);
  endtask : ready_low

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_self();
    axi_wr(IRQ_EN_OFS, 32'h1, RESP_OKAY);
    cmd(7'(MODE_SELF));
    mode_at(6 * P, MODE_SELF);
    chk(32'(irq), 32'h1);
    ready_low(9 * P);
    axi_rd(ZS_CAL_OFS, 32'h000100, RESP_OKAY);
    axi_rd(FS_CAL_OFS, 32'h010100, RESP_OKAY);
    axi_rd(DATA_OFS, 32'h4000, RESP_OKAY);
    axi_wr(IRQ_EN_OFS, 32'h0, RESP_OKAY);
    repeat (2) @(posedge ref_clk_i);
    chk(32'(irq), 32'h0);
    axi_rd(IRQ_STAT_OFS, 32'hFFFFFFFF, RESP_OKAY);
    chk(32'(rd[IRQ_CAL_BIT]), 32'h1);
    axi_wr(IRQ_CLR_OFS, 32'h1, RESP_OKAY);
    axi_rd(IRQ_STAT_OFS, 32'hFFFFFFFF, RESP_OKAY);
    chk(32'(rd[IRQ_CAL_BIT]), 32'h0);
  endtask : t_self

  task automatic sys_step(input logic [6:0] s, input logic [23:0] w, input logic [23:0] zs,
                          input logic [23:0] fs);
    analog <= w;
    cmd(s);
    mode_at(3 * P, s[1:0]);
    ready_low(4 * P);
    axi_rd(ZS_CAL_OFS, 32'(zs), RESP_OKAY);
    axi_rd(FS_CAL_OFS, 32'(fs), RESP_OKAY);
  endtask : sys_step

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    {rst_n_i, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    analog = 24'h004100;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    chk(32'({conv_ready_n, irq}), 32'h2);
    axi_rd(SETUP_OFS, 32'h0, RESP_OKAY);
    axi_rd(FS_CAL_OFS, 32'(FS_CAL_RST), RESP_OKAY);
    axi_rd(8'h20, 32'h0, RESP_SLVERR);
    axi_wr(STATUS_OFS, 32'h1, RESP_SLVERR);
    axi_rd(SETUP_OFS, 32'h0, RESP_OKAY);
    t_self();
    while (conv_ready_n !== 1'b0) @(posedge ref_clk_i);
    sys_step(7'(MODE_SYS_ZERO), 24'h002000, 24'h002000, 24'h010100);
    sys_step(7'(MODE_SYS_FULL), 24'h012000, 24'h002000, 24'h012000);
    // Bipolar, top gain: a repeated offset step on that same input reads back at midscale
    sys_step(7'h4E, 24'h003000, 24'h003000, 24'h012000);
    chk(32'({bipolar, gain_sel}), 32'h7);
    axi_rd(DATA_OFS, 32'h8000, RESP_OKAY);
    tally_and_finish();
  end
endmodule : testbench
